// file: hold_recovery_pkg.sv
// shared constants, types and helpers of the hold recovery and ratio control block
package hold_recovery_pkg;

  // controller states
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_CAL   = 3'h1,
    ST_TRACK = 3'h2,
    ST_HOLD  = 3'h3,
    ST_SLEW  = 3'h4
  } ctrl_state_t;

  // register byte addresses
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_SETTINGS = 5'h04;
  localparam logic [4:0] ADDR_RATIO    = 5'h08;
  localparam logic [4:0] ADDR_PHASE    = 5'h0c;
  localparam logic [4:0] ADDR_CONTROL  = 5'h10;

  // status, settings and control field positions
  localparam int STAT_HOLD_BIT   = 3;
  localparam int STAT_CAL_BIT    = 4;
  localparam int STAT_OUTEN_BIT  = 5;
  localparam int STAT_RANGE_BIT  = 6;
  localparam int CTRL_RECAL_BIT  = 0;
  localparam int SET_BW_LSB      = 9;

  // input range codes, 001 = 19 MHz up to 110 = 622 MHz
  localparam logic [2:0] IN_RANGE_FIRST = 3'h1;
  localparam logic [2:0] IN_RANGE_LAST  = 3'h6;

  // output range codes and their power-of-two exponents over the 19 MHz range
  localparam logic [1:0] OUT_RANGE_19  = 2'h1;
  localparam logic [1:0] OUT_RANGE_155 = 2'h2;
  localparam logic [1:0] OUT_RANGE_622 = 2'h3;
  localparam logic [2:0] OUT_EXP_19    = 3'h0;
  localparam logic [2:0] OUT_EXP_155   = 3'h3;
  localparam logic [2:0] OUT_EXP_622   = 3'h5;

  // error correction scaling codes and factors
  localparam logic [1:0] FEC_NONE = 2'h0;
  localparam logic [1:0] FEC_UP   = 2'h1;
  localparam logic [1:0] FEC_DOWN = 2'h2;
  localparam logic [7:0] FEC_255  = 8'hff;
  localparam logic [7:0] FEC_238  = 8'hee;
  localparam logic [7:0] FEC_UNIT = 8'h01;

  // slew counter reload per loop bandwidth setting, one less than the cycles between phase steps
  localparam logic [7:0] SLEW_PERIOD_BW0 = 8'h40;
  localparam logic [7:0] SLEW_PERIOD_BW1 = 8'h20;
  localparam logic [7:0] SLEW_PERIOD_BW2 = 8'h10;
  localparam logic [7:0] SLEW_PERIOD_BW3 = 8'h08;

  // an undriven pin reads as low
  function automatic logic pulled(input logic b);
    return (b === 1'b1);
  endfunction

  // slew period for a bandwidth code
  function automatic logic [7:0] slew_period(input logic [1:0] bw);
    case (bw)
      2'h0:    return SLEW_PERIOD_BW0;
      2'h1:    return SLEW_PERIOD_BW1;
      2'h2:    return SLEW_PERIOD_BW2;
      default: return SLEW_PERIOD_BW3;
    endcase
  endfunction

endpackage

// file: strap_capture.sv
// captures static configuration pins with pull-down behaviour on a capture pulse
`timescale 1ns/100ps
module strap_capture #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         capture,
  input  wire logic [W-1:0] straps_in,
  output logic      [W-1:0] straps_q
);

  if (W < 1) begin : g_bad_w
    $error("strap_capture needs at least one bit");
  end

  logic [W-1:0] straps_d;

  // one capture flop per strap bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    // undriven pins count as low, sampled only on capture
    always_comb begin
      straps_d[i] = straps_q[i];
      if (capture) begin
        straps_d[i] = hold_recovery_pkg::pulled(straps_in[i]);
      end
    end

    // register the bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        straps_q[i] <= 1'b0;
      end else begin
        straps_q[i] <= straps_d[i];
      end
    end
  end

endmodule // strap_capture

// file: ratio_decoder.sv
// decodes range and scaling settings into a multiplication ratio
`timescale 1ns/100ps
module ratio_decoder (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  in_range,
  input  wire logic [1:0]  out_range,
  input  wire logic [1:0]  fec,
  output logic      [15:0] ratio_num_q,
  output logic      [15:0] ratio_den_q,
  output logic             range_error_q
);

  logic [15:0] num_d;
  logic [15:0] den_d;
  logic        err_d;
  logic [2:0]  out_exp;
  logic [2:0]  in_exp;
  logic [7:0]  fnum;
  logic [7:0]  fden;

  // ratio = fnum * 2^out_exp / (fden * 2^(in_range-1))
  always_comb begin
    err_d   = 1'b0;
    in_exp  = in_range - 3'h1;
    out_exp = hold_recovery_pkg::OUT_EXP_19;
    fnum    = hold_recovery_pkg::FEC_UNIT;
    fden    = hold_recovery_pkg::FEC_UNIT;
    if (in_range < hold_recovery_pkg::IN_RANGE_FIRST ||
        in_range > hold_recovery_pkg::IN_RANGE_LAST) begin
      err_d = 1'b1;
    end
    case (out_range)
      hold_recovery_pkg::OUT_RANGE_19:  out_exp = hold_recovery_pkg::OUT_EXP_19;
      hold_recovery_pkg::OUT_RANGE_155: out_exp = hold_recovery_pkg::OUT_EXP_155;
      hold_recovery_pkg::OUT_RANGE_622: out_exp = hold_recovery_pkg::OUT_EXP_622;
      default:                          err_d   = 1'b1;
    endcase
    case (fec)
      hold_recovery_pkg::FEC_NONE: ;
      hold_recovery_pkg::FEC_UP: begin
        fnum = hold_recovery_pkg::FEC_255;
        fden = hold_recovery_pkg::FEC_238;
      end
      hold_recovery_pkg::FEC_DOWN: begin
        fnum = hold_recovery_pkg::FEC_238;
        fden = hold_recovery_pkg::FEC_255;
      end
      default: err_d = 1'b1;
    endcase
    num_d = 16'(fnum) << out_exp;
    den_d = 16'(fden) << in_exp;
    if (err_d) begin
      num_d = 16'h0000;
      den_d = 16'h0000;
    end
  end

  // register the ratio
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratio_num_q   <= 16'h0000;
      ratio_den_q   <= 16'h0000;
      range_error_q <= 1'b0;
    end else begin
      ratio_num_q   <= num_d;
      ratio_den_q   <= den_d;
      range_error_q <= err_d;
    end
  end

endmodule // ratio_decoder

// file: hold_recovery_ratio_control.sv
// hold recovery, phase build-out and ratio control with an avalon register slave
// Function
// - with fixed phase mode high, leaving hold is not hitless.
// - with fixed phase mode high, output phase returns to the default relation.
// - that phase return moves at a rate set by loop bandwidth select and double bandwidth.
// - with fixed phase mode low, build-out absorbs the phase difference on hold exit.
// - after build-out the phase relation at switch-back time is kept.
// - multiplication factor comes from input range, output range and error correction scaling.
// - undriven control inputs read as low.
// - input range 001..110 maps 19..622 MHz; 000 and 111 reserved.
// - hold entered only on reference loss and shown on hold_active.
// - reset/calibrate low holds the reset state; its rising edge starts self-calibration.
`timescale 1ns/100ps
module hold_recovery_ratio_control #(
  parameter int PHASE_W    = 16,
  parameter int CAL_CYCLES = 1024
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               reset_calibrate_n,
  input  wire logic               fixed_phase_mode,
  input  wire logic               double_bandwidth,
  input  wire logic [1:0]         loop_bandwidth_select,
  input  wire logic [2:0]         input_range_select,
  input  wire logic [1:0]         output_range_select,
  input  wire logic [1:0]         error_correction_scaling,
  input  wire logic               reference_lost,
  input  wire logic [PHASE_W-1:0] phase_diff,
  input  wire logic [4:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  output logic                    hold_active,
  output logic                    calibrating,
  output logic                    clock_out_enable,
  output logic      [PHASE_W-1:0] phase_offset,
  output logic      [15:0]        ratio_num,
  output logic      [15:0]        ratio_den,
  output logic                    range_error
);

  if (PHASE_W < 4 || PHASE_W > 32) begin : g_bad_phase_w
    $error("PHASE_W must lie between 4 and 32");
  end
  if (CAL_CYCLES < 2) begin : g_bad_cal
    $error("CAL_CYCLES must be at least 2");
  end

  localparam int CW      = $clog2(CAL_CYCLES);
  localparam int STRAP_W = 9;

  hold_recovery_pkg::ctrl_state_t state_q, state_d;

  logic                      rcal_q;
  logic                      rcal_now;
  logic                      rcal_rise;
  logic [STRAP_W-1:0]        straps_in;
  logic [STRAP_W-1:0]        straps_q;
  logic                      fixed_q;
  logic                      dbl_q;
  logic [1:0]                bw_now;
  logic [CW-1:0]             cal_cnt_q, cal_cnt_d;
  logic [7:0]                slew_cnt_q, slew_cnt_d;
  logic                      slew_tick;
  logic signed [PHASE_W-1:0] offset_q, offset_d;
  logic signed [PHASE_W-1:0] step;
  logic                      hold_q, hold_d;
  logic                      cal_q, cal_d;
  logic                      outen_q, outen_d;
  logic                      ack_q, ack_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      recal_req;

  // undriven pins read low; reset/calibrate edge detection
  assign rcal_now  = hold_recovery_pkg::pulled(reset_calibrate_n);
  assign bw_now    = {hold_recovery_pkg::pulled(loop_bandwidth_select[1]),
                      hold_recovery_pkg::pulled(loop_bandwidth_select[0])};
  assign rcal_rise = rcal_now & ~rcal_q;

  // strap order: fixed, double, scaling, output range, input range
  assign straps_in = {fixed_phase_mode, double_bandwidth, error_correction_scaling,
                      output_range_select, input_range_select};

  // settings sampled on the reset/calibrate rise
  strap_capture #(
    .W (STRAP_W)
  ) u_straps (
    .clk       (clk),
    .rst_n     (rst_n),
    .capture   (rcal_rise),
    .straps_in (straps_in),
    .straps_q  (straps_q)
  );

  assign fixed_q = straps_q[8];
  assign dbl_q   = straps_q[7];

  // multiplication ratio from sampled settings
  ratio_decoder u_ratio (
    .clk           (clk),
    .rst_n         (rst_n),
    .in_range      (straps_q[2:0]),
    .out_range     (straps_q[4:3]),
    .fec           (straps_q[6:5]),
    .ratio_num_q   (ratio_num),
    .ratio_den_q   (ratio_den),
    .range_error_q (range_error)
  );

  // slew step doubles with double bandwidth
  assign step      = dbl_q ? PHASE_W'(2) : PHASE_W'(1);
  assign slew_tick = (slew_cnt_q == 8'h00);

  // controller next state
  always_comb begin
    state_d    = state_q;
    cal_cnt_d  = cal_cnt_q;
    slew_cnt_d = slew_cnt_q;
    offset_d   = offset_q;
    case (state_q)
      hold_recovery_pkg::ST_RESET: begin
        offset_d = '0;
        if (rcal_rise) begin
          state_d   = hold_recovery_pkg::ST_CAL;
          cal_cnt_d = '0;
        end
      end
      hold_recovery_pkg::ST_CAL: begin
        offset_d = '0;
        if (!reference_lost) begin
          cal_cnt_d = cal_cnt_q + CW'(1);
          if (cal_cnt_q == CW'(CAL_CYCLES - 1)) begin
            state_d = hold_recovery_pkg::ST_TRACK;
          end
        end
      end
      hold_recovery_pkg::ST_TRACK: begin
        if (reference_lost) begin
          state_d = hold_recovery_pkg::ST_HOLD;
        end
      end
      hold_recovery_pkg::ST_HOLD: begin
        if (!reference_lost) begin
          offset_d = phase_diff;
          if (fixed_q) begin
            state_d    = hold_recovery_pkg::ST_SLEW;
            slew_cnt_d = hold_recovery_pkg::slew_period(bw_now);
          end else begin
            state_d = hold_recovery_pkg::ST_TRACK;
          end
        end
      end
      hold_recovery_pkg::ST_SLEW: begin
        if (reference_lost) begin
          state_d = hold_recovery_pkg::ST_HOLD;
        end else if (slew_tick) begin
          slew_cnt_d = hold_recovery_pkg::slew_period(bw_now);
          if (offset_q > step) begin
            offset_d = offset_q - step;
          end else if (offset_q < -step) begin
            offset_d = offset_q + step;
          end else begin
            offset_d = '0;
            state_d  = hold_recovery_pkg::ST_TRACK;
          end
        end else begin
          slew_cnt_d = slew_cnt_q - 8'h01;
        end
      end
      default: state_d = hold_recovery_pkg::ST_RESET;
    endcase
    if (recal_req && state_q != hold_recovery_pkg::ST_RESET) begin
      state_d   = hold_recovery_pkg::ST_CAL;
      cal_cnt_d = '0;
      offset_d  = '0;
    end
    if (!rcal_now) begin
      state_d = hold_recovery_pkg::ST_RESET;
    end
  end

  // status flags follow the next state
  always_comb begin
    hold_d  = (state_d == hold_recovery_pkg::ST_HOLD);
    cal_d   = (state_d == hold_recovery_pkg::ST_CAL);
    outen_d = (state_d != hold_recovery_pkg::ST_RESET);
  end

  // controller registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= hold_recovery_pkg::ST_RESET;
      rcal_q     <= 1'b0;
      cal_cnt_q  <= '0;
      slew_cnt_q <= 8'h00;
      offset_q   <= '0;
      hold_q     <= 1'b0;
      cal_q      <= 1'b0;
      outen_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      rcal_q     <= rcal_now;
      cal_cnt_q  <= cal_cnt_d;
      slew_cnt_q <= slew_cnt_d;
      offset_q   <= offset_d;
      hold_q     <= hold_d;
      cal_q      <= cal_d;
      outen_q    <= outen_d;
    end
  end

  assign hold_active      = hold_q;
  assign calibrating      = cal_q;
  assign clock_out_enable = outen_q;
  assign phase_offset     = offset_q;

  // bus slave: one wait cycle, then the answer
  assign waitrequest = (read | write) & ~ack_q;
  assign recal_req   = write & ack_q & (address == hold_recovery_pkg::ADDR_CONTROL) &
                       writedata[hold_recovery_pkg::CTRL_RECAL_BIT];

  // read data prepared during the wait cycle; unmapped reads return zero
  always_comb begin
    ack_d   = (read | write) & ~ack_q;
    rdata_d = rdata_q;
    if (read && !ack_q) begin
      rdata_d = 32'h0000_0000;
      if (address == hold_recovery_pkg::ADDR_STATUS) begin
        rdata_d[2:0]                              = state_q;
        rdata_d[hold_recovery_pkg::STAT_HOLD_BIT]  = hold_q;
        rdata_d[hold_recovery_pkg::STAT_CAL_BIT]   = cal_q;
        rdata_d[hold_recovery_pkg::STAT_OUTEN_BIT] = outen_q;
        rdata_d[hold_recovery_pkg::STAT_RANGE_BIT] = range_error;
      end else if (address == hold_recovery_pkg::ADDR_SETTINGS) begin
        rdata_d[STRAP_W-1:0] = straps_q;
        rdata_d[hold_recovery_pkg::SET_BW_LSB +: 2] = bw_now;
      end else if (address == hold_recovery_pkg::ADDR_RATIO) begin
        rdata_d = {ratio_num, ratio_den};
      end else if (address == hold_recovery_pkg::ADDR_PHASE) begin
        rdata_d = 32'(offset_q);
      end
    end
  end

  // bus registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign readdata = rdata_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hold_on_loss: assert property (
    state_q == hold_recovery_pkg::ST_TRACK && reference_lost && rcal_now && !recal_req
    |=> hold_active && state_q == hold_recovery_pkg::ST_HOLD)
    else $error("hold not entered on reference loss");

  a_hold_only_lost: assert property (
    $rose(hold_active) |-> $past(reference_lost))
    else $error("hold entered without reference loss");

  a_fixed_no_hitless: assert property (
    state_q == hold_recovery_pkg::ST_HOLD && !reference_lost && fixed_q && rcal_now
    && !recal_req |=> state_q == hold_recovery_pkg::ST_SLEW)
    else $error("fixed mode exit did not slew");

  a_buildout_capture: assert property (
    state_q == hold_recovery_pkg::ST_HOLD && !reference_lost && !fixed_q && rcal_now
    && !recal_req |=> offset_q == $past(phase_diff) && state_q == hold_recovery_pkg::ST_TRACK)
    else $error("build-out did not absorb phase");

  a_offset_kept: assert property (
    state_q == hold_recovery_pkg::ST_TRACK && $past(state_q) == hold_recovery_pkg::ST_TRACK
    |-> $stable(offset_q))
    else $error("phase relation moved while tracking");

  a_slew_waits: assert property (
    state_q == hold_recovery_pkg::ST_SLEW && !slew_tick && !recal_req |=> $stable(offset_q))
    else $error("phase moved between slew steps");

  a_slew_step: assert property (
    state_q == hold_recovery_pkg::ST_SLEW && slew_tick && !reference_lost && rcal_now
    && !recal_req && offset_q > step |=> offset_q == $past(offset_q) - $past(step))
    else $error("slew step wrong");

  a_cal_start: assert property (
    rcal_rise |=> state_q == hold_recovery_pkg::ST_CAL && calibrating ##1 !hold_active)
    else $error("calibration not started on rise");

  a_reset_mode: assert property (
    !rcal_now |=> state_q == hold_recovery_pkg::ST_RESET && !clock_out_enable)
    else $error("reset mode not entered");

  a_strap_sample: assert property (
    rcal_rise |=> fixed_q == $past(hold_recovery_pkg::pulled(fixed_phase_mode)))
    else $error("fixed mode not sampled at rise");

endmodule // hold_recovery_ratio_control

// file: strap_driver.sv
// board-side model driving the strap pins and the reset/calibrate pin
`timescale 1ns/100ps
module strap_driver (
  input  wire logic       clk,
  input  wire logic       rcal_req,
  input  wire logic       want_fixed,
  input  wire logic       want_dbl,
  input  wire logic [2:0] want_in,
  input  wire logic [1:0] want_out,
  input  wire logic [1:0] want_fec,
  input  wire logic       float_fec,
  output logic            reset_calibrate_n,
  output logic            fixed_phase_mode,
  output logic            double_bandwidth,
  output logic      [2:0] input_range_select,
  output logic      [1:0] output_range_select,
  output wire logic [1:0] error_correction_scaling
);
  logic [1:0] fec_q;

  // mode straps move only while the reset/calibrate pin is low
  always_ff @(posedge clk) begin
    reset_calibrate_n   <= rcal_req;
    input_range_select  <= want_in;
    output_range_select <= want_out;
    fec_q               <= want_fec;
    if (reset_calibrate_n === 1'b0) begin
      fixed_phase_mode <= want_fixed | want_dbl;
      double_bandwidth <= want_dbl;
    end
  end

  // a floated strap is left undriven for the internal pull-down
  assign error_correction_scaling = float_fec ? 2'bzz : fec_q;
endmodule // strap_driver

// file: hold_recovery_ratio_control_tb.sv
// self-checking bench for the hold recovery and ratio control block
`timescale 1ns/100ps
module hold_recovery_ratio_control_tb;
  logic        clk, rst_n, rcal_req, want_fixed, want_dbl, float_fec;
  logic        reference_lost, read, write;
  logic [2:0]  want_in;
  logic [1:0]  want_out, want_fec, loop_bandwidth_select;
  logic [15:0] phase_diff;
  logic [4:0]  address;
  logic [31:0] writedata, d;
  wire  logic  reset_calibrate_n, fixed_phase_mode, double_bandwidth;
  wire  logic  waitrequest, hold_active, calibrating, clock_out_enable, range_error;
  wire  logic [2:0]  input_range_select;
  wire  logic [1:0]  output_range_select, error_correction_scaling;
  wire  logic [31:0] readdata;
  wire  logic [15:0] phase_offset, ratio_num, ratio_den;
  int          error_cnt, tests_run, n;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  hold_recovery_ratio_control #(.PHASE_W(16), .CAL_CYCLES(4)) dut (
    .clk(clk), .rst_n(rst_n), .reset_calibrate_n(reset_calibrate_n),
    .fixed_phase_mode(fixed_phase_mode), .double_bandwidth(double_bandwidth),
    .loop_bandwidth_select(loop_bandwidth_select), .input_range_select(input_range_select),
    .output_range_select(output_range_select),
    .error_correction_scaling(error_correction_scaling), .reference_lost(reference_lost),
    .phase_diff(phase_diff), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hold_active(hold_active), .calibrating(calibrating),
    .clock_out_enable(clock_out_enable), .phase_offset(phase_offset),
    .ratio_num(ratio_num), .ratio_den(ratio_den), .range_error(range_error));

  strap_driver board (
    .clk(clk), .rcal_req(rcal_req), .want_fixed(want_fixed), .want_dbl(want_dbl),
    .want_in(want_in), .want_out(want_out), .want_fec(want_fec), .float_fec(float_fec),
    .reset_calibrate_n(reset_calibrate_n), .fixed_phase_mode(fixed_phase_mode),
    .double_bandwidth(double_bandwidth), .input_range_select(input_range_select),
    .output_range_select(output_range_select),
    .error_correction_scaling(error_correction_scaling));

  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    address   <= a;
    writedata <= wd;
    read      <= ~wr;
    write     <= wr;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // wait for calibration to start and run out
  task automatic wait_cal();
    for (n = 0; n < 40 && calibrating !== 1'b1; n++) @(negedge clk);
    chk({31'h0, calibrating}, 32'h1);
    for (n = 0; n < 400 && calibrating !== 1'b0; n++) @(negedge clk);
    chk({31'h0, calibrating}, 32'h0);
    chk({31'h0, clock_out_enable}, 32'h1);
  endtask

  // restart through the pin with new straps, then read them back
  task automatic calib(input logic fx, input logic db, input logic [2:0] ir,
                       input logic [1:0] orr, input logic [1:0] fe, input logic fl);
    @(posedge clk);
    rcal_req   <= 1'b0;
    want_fixed <= fx;
    want_dbl   <= db;
    want_in    <= ir;
    want_out   <= orr;
    want_fec   <= fe;
    float_fec  <= fl;
    repeat (4) @(posedge clk);
    bus(1'b0, hold_recovery_pkg::ADDR_STATUS, 32'h0, d);
    chk({26'h0, d[5:0]}, 32'h0);
    rcal_req <= 1'b1;
    wait_cal();
    @(posedge clk);
    want_in <= ~ir;
    repeat (3) @(posedge clk);
    bus(1'b0, hold_recovery_pkg::ADDR_SETTINGS, 32'h0, d);
    chk({21'h0, d[10:0]},
        {21'h0, loop_bandwidth_select, fx | db, db, fl ? 2'h0 : fe, orr, ir});
  endtask

  // lose the reference, come back with a new phase difference
  task automatic hold_exit(input logic [15:0] pd, input logic [1:0] bw);
    @(posedge clk);
    reference_lost        <= 1'b1;
    phase_diff            <= pd;
    loop_bandwidth_select <= bw;
    repeat (2) @(negedge clk);
    chk({31'h0, hold_active}, 32'h1);
    repeat (3) @(posedge clk);
    reference_lost <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, hold_active}, 32'h0);
    chk({16'h0, phase_offset}, {16'h0, pd});
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog against a hung wait
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial begin
    {rst_n, rcal_req, want_fixed, want_dbl, float_fec, reference_lost} = 6'h0;
    {read, write, want_in, want_out, want_fec, loop_bandwidth_select} = 11'h0;
    {phase_diff, address, writedata} = 53'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b1, 5'h14, 32'hffffffff, d);
    bus(1'b0, 5'h14, 32'h0, d);
    chk(d, 32'h0);
    // fixed mode: phase slews back at the bandwidth rate
    calib(1'b1, 1'b0, 3'h1, hold_recovery_pkg::OUT_RANGE_622, hold_recovery_pkg::FEC_UP, 1'b0);
    chk({16'h0, ratio_num} * 32'd238, {16'h0, ratio_den} * 32'd8160);
    chk({31'h0, range_error}, 32'h0);
    for (int b = 3; b >= 1; b -= 2) begin
      hold_exit(16'h0040, b[1:0]);
      for (n = 0; n < 5000 && phase_offset !== 16'h0; n++) @(negedge clk);
      chk({31'h0, n >= 64 * (b == 3 ? 8 : 32) && n <= 64 * (b == 3 ? 10 : 34)}, 32'h1);
      bus(1'b0, hold_recovery_pkg::ADDR_STATUS, 32'h0, d);
      chk({28'h0, d[3:0]}, 32'h2);
    end
    // build-out mode keeps the switch-back phase
    calib(1'b0, 1'b0, 3'h4, hold_recovery_pkg::OUT_RANGE_155, hold_recovery_pkg::FEC_DOWN, 1'b0);
    chk({16'h0, ratio_num} * 32'd255, {16'h0, ratio_den} * 32'd238);
    hold_exit(16'hffc0, 2'h3);
    repeat (300) @(posedge clk);
    chk({16'h0, phase_offset}, 32'h0000ffc0);
    bus(1'b0, hold_recovery_pkg::ADDR_STATUS, 32'h0, d);
    chk({28'h0, d[3:0]}, 32'h2);
    // restart calibration from the control register
    bus(1'b1, hold_recovery_pkg::ADDR_CONTROL, 32'h1, d);
    wait_cal();
    chk({16'h0, phase_offset}, 32'h0);
    // reserved input range code 000, scaling pins left floating
    calib(1'b1, 1'b1, 3'h0, hold_recovery_pkg::OUT_RANGE_19, hold_recovery_pkg::FEC_UP, 1'b1);
    chk({31'h0, range_error}, 32'h1);
    chk({ratio_num, ratio_den}, 32'h0);
    // double bandwidth: twice the step, so half the steps at the same period; then reserved input range code 111
    hold_exit(16'h0040, 2'h3);
    for (n = 0; n < 5000 && phase_offset !== 16'h0; n++) @(negedge clk);
    chk({31'h0, n >= 32 * 8 && n <= 32 * 10}, 32'h1);
    calib(1'b1, 1'b0, 3'h7, hold_recovery_pkg::OUT_RANGE_19, hold_recovery_pkg::FEC_DOWN, 1'b0);
    chk({31'h0, range_error}, 32'h1);
    bus(1'b0, hold_recovery_pkg::ADDR_RATIO, 32'h0, d);
    chk(d, 32'h0);
    finish_test();
  end
endmodule // hold_recovery_ratio_control_tb
